// ### verilog/dsps_pkg.sv
`default_nettype none
package dsps_pkg;
  // Phase codes driven onto the front end's two phase pins
  localparam logic [1:0] PH_CLEAR = 2'b00;
  localparam logic [1:0] PH_NULL = 2'b01;
  localparam logic [1:0] PH_INTEG = 2'b10;
  localparam logic [1:0] PH_RAMP = 2'b11;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INT_LEN = 8'h04;
  localparam logic [7:0] OFF_NULL_LEN = 8'h08;
  localparam logic [7:0] OFF_MAX_RAMP = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RESULT = 8'h14;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CHAN_LSB = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_OVR_BIT = 2;
  localparam int ST_SIGN_BIT = 3;
  localparam int ST_PHASE_LSB = 4;
  localparam int ST_CHAN_LSB = 8;

  // Reset values (cycles of the 100 MHz clock); 66 ms integration
  localparam logic [31:0] INT_LEN_RST = 32'h0064_b540;
  localparam logic [31:0] NULL_LEN_RST = 32'h0064_b540;
  localparam logic [31:0] MAX_RAMP_RST = 32'h00c9_6a80;

  // Comparator lag, for budgeting single-count error
  localparam int CMP_LAG_NS = 2000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CMP_LAG_CYC = CMP_LAG_NS / CLK_PERIOD_NS;

  // AHB transfer type and response codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HRESP_OKAY = 2'b00;

  typedef enum logic [2:0] {
    ST_IDLE_NULL,
    ST_NULL_RUN,
    ST_INTEG,
    ST_RAMP,
    ST_CLEAR
  } dsps_state_t;
endpackage
`default_nettype wire

// ### verilog/dsps_regs.sv
`default_nettype none
// Small register store for the three timing words, read data registered
module dsps_regs #(
  parameter int DW = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic we_in,
  input wire logic [1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [1:0] raddr_in,
  output logic [DW-1:0] rdata_out,
  output logic [DW-1:0] int_len_out,
  output logic [DW-1:0] null_len_out,
  output logic [DW-1:0] max_ramp_out
);
  import dsps_pkg::*;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_len_out <= DW'(INT_LEN_RST);
      null_len_out <= DW'(NULL_LEN_RST);
      max_ramp_out <= DW'(MAX_RAMP_RST);
    end else if (we_in) begin
      if (waddr_in == 2'h1) begin
        int_len_out <= wdata_in;
      end else if (waddr_in == 2'h2) begin
        null_len_out <= wdata_in;
      end else if (waddr_in == 2'h3) begin
        max_ramp_out <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (raddr_in == 2'h1) begin
      rdata_out <= int_len_out;
    end else if (raddr_in == 2'h2) begin
      rdata_out <= null_len_out;
    end else if (raddr_in == 2'h3) begin
      rdata_out <= max_ramp_out;
    end else begin
      rdata_out <= '0;
    end
  end
endmodule
`default_nettype wire

// ### verilog/dsps_sequencer.sv
`default_nettype none
// Functional notes
// - End nulling once comparator returns high
// - Nulling lasts about the integration length
// - Nulling is the idle phase, unlimited
// - Integration length fixed every conversion
// - Sample comparator just before ramp starts
// - Sampled level is the result sign
// - Count from ramp start to comparator fall
// - Clear with code 00 until comparator high
// - Leave clearing at once when comparator high
// - Then hold nulling code 01 until start
// - Integration length a whole mains period multiple
// - Two-bit channel select, 00 is channel 0
// - Ramp right after integration, stop at crossing
// - Ramp limit about twice integration count
module dsps_sequencer #(
  parameter int CW = 32
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HSEL_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic ZERO_CROSS_OUT_IN,
  output logic [1:0] PHASE_CODE_OUT,
  output logic CHAN_SEL_HI_OUT,
  output logic CHAN_SEL_LO_OUT
);
  import dsps_pkg::*;

  dsps_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] result_q;
  logic sign_q;
  logic ovr_q;
  logic done_q;
  logic start_q;
  logic [1:0] chan_q;
  logic [1:0] phase_q;
  logic cmp_d1_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_local_q;
  logic [31:0] local_rdata_q;
  logic [31:0] store_rdata;
  logic [31:0] int_len;
  logic [31:0] null_len;
  logic [31:0] max_ramp;
  logic start_pulse;
  logic addr_ok;
  logic cmp_fall;

  function automatic logic [1:0] reg_index(input logic [7:0] a);
    if (a == OFF_INT_LEN) begin
      reg_index = 2'h1;
    end else if (a == OFF_NULL_LEN) begin
      reg_index = 2'h2;
    end else if (a == OFF_MAX_RAMP) begin
      reg_index = 2'h3;
    end else begin
      reg_index = 2'h0;
    end
  endfunction

  function automatic logic reached(input logic [CW-1:0] c, input logic [31:0] lim);
    reached = (c + CW'(1)) >= CW'(lim);
  endfunction

  assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1] && (HSIZE_IN == 3'h2);
  assign start_pulse = wr_pend_q && (wr_addr_q == OFF_CTRL) && HWDATA_IN[CTRL_START_BIT];
  // Ramp ends on a falling edge: a comparator still lagging low after a negative integration must not end it
  assign cmp_fall = cmp_d1_q && !ZERO_CROSS_OUT_IN;

  // Address phase capture; slave is always zero-wait and OKAY
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_ok && HWRITE_IN;
      if (addr_ok) begin
        wr_addr_q <= HADDR_IN[7:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      HREADYOUT_OUT <= 1'b0;
      HRESP_OUT <= 1'b0;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= HRESP_OKAY[0];
    end
  end

  dsps_regs #(
    .DW(32)
  ) u_regs (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .we_in(wr_pend_q),
    .waddr_in(reg_index(wr_addr_q)),
    .wdata_in(HWDATA_IN),
    .raddr_in(reg_index(HADDR_IN[7:0])),
    .rdata_out(store_rdata),
    .int_len_out(int_len),
    .null_len_out(null_len),
    .max_ramp_out(max_ramp)
  );

  // Read data for control, status and result words, registered in the address phase
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      local_rdata_q <= '0;
      rd_local_q <= 1'b0;
    end else if (addr_ok && !HWRITE_IN) begin
      rd_local_q <= reg_index(HADDR_IN[7:0]) == 2'h0;
      local_rdata_q <= '0;
      if (HADDR_IN[7:0] == OFF_CTRL) begin
        local_rdata_q[CTRL_CHAN_LSB +: 2] <= chan_q;
      end else if (HADDR_IN[7:0] == OFF_STATUS) begin
        local_rdata_q[ST_BUSY_BIT] <= state_q != ST_IDLE_NULL;
        local_rdata_q[ST_DONE_BIT] <= done_q;
        local_rdata_q[ST_OVR_BIT] <= ovr_q;
        local_rdata_q[ST_SIGN_BIT] <= sign_q;
        local_rdata_q[ST_PHASE_LSB +: 2] <= phase_q;
        local_rdata_q[ST_CHAN_LSB +: 2] <= chan_q;
      end else if (HADDR_IN[7:0] == OFF_RESULT) begin
        local_rdata_q <= 32'(result_q);
      end
    end
  end

  always_comb begin
    if (rd_local_q) begin
      HRDATA_OUT = local_rdata_q;
    end else begin
      HRDATA_OUT = store_rdata;
    end
  end

  // Control word: channel select and start request
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      chan_q <= '0;
      start_q <= 1'b0;
    end else begin
      if (wr_pend_q && wr_addr_q == OFF_CTRL && state_q == ST_IDLE_NULL) begin
        chan_q <= HWDATA_IN[CTRL_CHAN_LSB +: 2];
      end
      if (start_pulse) begin
        start_q <= 1'b1;
      end else if (state_q == ST_NULL_RUN) begin
        start_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cmp_d1_q <= 1'b1;
    end else begin
      cmp_d1_q <= ZERO_CROSS_OUT_IN;
    end
  end

  // Conversion sequencing
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_q <= ST_IDLE_NULL;
      cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE_NULL: begin
          cnt_q <= '0;
          if (start_q) begin
            state_q <= ST_NULL_RUN;
          end
        end
        ST_NULL_RUN: begin
          cnt_q <= cnt_q + CW'(1);
          // Minimum nulling time elapsed and comparator back high
          if (reached(cnt_q, null_len) && ZERO_CROSS_OUT_IN) begin
            state_q <= ST_INTEG;
            cnt_q <= '0;
          end
        end
        ST_INTEG: begin
          cnt_q <= cnt_q + CW'(1);
          if (reached(cnt_q, int_len)) begin
            state_q <= ST_RAMP;
            cnt_q <= '0;
          end
        end
        ST_RAMP: begin
          cnt_q <= cnt_q + CW'(1);
          if (cmp_fall || reached(cnt_q, max_ramp)) begin
            state_q <= ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          cnt_q <= '0;
          if (ZERO_CROSS_OUT_IN) begin
            state_q <= ST_IDLE_NULL;
          end
        end
        default: begin
          state_q <= ST_IDLE_NULL;
        end
      endcase
    end
  end

  // Sign, magnitude and over-range capture
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sign_q <= 1'b0;
      result_q <= '0;
      ovr_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (state_q == ST_INTEG && reached(cnt_q, int_len)) begin
        sign_q <= ZERO_CROSS_OUT_IN;
      end
      if (state_q == ST_RAMP && cmp_fall) begin
        // Count includes the comparator lag of about CMP_LAG_CYC cycles
        result_q <= cnt_q;
        ovr_q <= 1'b0;
      end else if (state_q == ST_RAMP && reached(cnt_q, max_ramp)) begin
        result_q <= cnt_q + CW'(1);
        ovr_q <= 1'b1;
      end
      if (state_q == ST_CLEAR && ZERO_CROSS_OUT_IN) begin
        done_q <= 1'b1;
      end else if (start_pulse) begin
        done_q <= 1'b0;
      end
    end
  end

  // Phase pins, registered
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PHASE_CODE_OUT <= PH_NULL;
      phase_q <= PH_NULL;
      CHAN_SEL_HI_OUT <= 1'b0;
      CHAN_SEL_LO_OUT <= 1'b0;
    end else begin
      CHAN_SEL_HI_OUT <= chan_q[1];
      CHAN_SEL_LO_OUT <= chan_q[0];
      case (state_q)
        ST_INTEG: begin
          PHASE_CODE_OUT <= reached(cnt_q, int_len) ? PH_RAMP : PH_INTEG;
          phase_q <= reached(cnt_q, int_len) ? PH_RAMP : PH_INTEG;
        end
        ST_RAMP: begin
          if (cmp_fall || reached(cnt_q, max_ramp)) begin
            PHASE_CODE_OUT <= PH_CLEAR;
            phase_q <= PH_CLEAR;
          end else begin
            PHASE_CODE_OUT <= PH_RAMP;
            phase_q <= PH_RAMP;
          end
        end
        ST_CLEAR: begin
          PHASE_CODE_OUT <= ZERO_CROSS_OUT_IN ? PH_NULL : PH_CLEAR;
          phase_q <= ZERO_CROSS_OUT_IN ? PH_NULL : PH_CLEAR;
        end
        ST_NULL_RUN: begin
          if (reached(cnt_q, null_len) && ZERO_CROSS_OUT_IN) begin
            PHASE_CODE_OUT <= PH_INTEG;
            phase_q <= PH_INTEG;
          end else begin
            PHASE_CODE_OUT <= PH_NULL;
            phase_q <= PH_NULL;
          end
        end
        default: begin
          PHASE_CODE_OUT <= PH_NULL;
          phase_q <= PH_NULL;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### dv/dsps_props.sv
`default_nettype none
module dsps_props (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic HREADYOUT_OUT,
  input wire logic ZERO_CROSS_OUT_IN,
  input wire logic [1:0] PHASE_CODE_OUT,
  input wire logic CHAN_SEL_HI_OUT,
  input wire logic CHAN_SEL_LO_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  wire logic [1:0] ph = PHASE_CODE_OUT;
  wire logic zc = ZERO_CROSS_OUT_IN;
  a_phase_legal: assert property (ph != $past(ph) |-> {$past(ph), ph} inside {4'h6, 4'hb, 4'hc, 4'h1})
    else $error("illegal phase step");
  a_clear_hold: assert property (ph == 2'h0 && !zc && !$past(zc) |=> ph == 2'h0)
    else $error("clearing left early");
  a_clear_exit: assert property (ph == 2'h0 && zc |-> ##[1:2] ph == 2'h1)
    else $error("clearing left late");
  a_ramp_exit: assert property (ph == 2'h3 && $fell(zc) |-> ##[1:2] ph == 2'h0)
    else $error("ramp not stopped");
  a_null_exit: assert property ($past(ph) == 2'h1 && ph == 2'h2 |-> $past(zc) || $past(zc, 2))
    else $error("nulling left with comparator low");
  a_integ_min: assert property ($past(ph) != 2'h2 && ph == 2'h2 |=> ph == 2'h2)
    else $error("integration too short");
  a_chan_stable: assert property (ph != 2'h1 && $past(ph) != 2'h1 |-> $stable({CHAN_SEL_HI_OUT, CHAN_SEL_LO_OUT}))
    else $error("channel moved in conversion");
  a_ready_high: assert property (!$past(RST_IN) |-> HREADYOUT_OUT)
    else $error("bus not ready");
endmodule
`default_nettype wire

// ### dv/dsps_fe_model.sv
`default_nettype none
module dsps_fe_model #(
  parameter int LAG = 5
) (
  input wire logic clk_in,
  input wire logic [1:0] phase_code_in,
  input wire logic chan_sel_hi_in,
  input wire logic chan_sel_lo_in,
  input wire logic signed [7:0] vin_in [4],
  input wire logic [15:0] null_low_in,
  output logic zero_cross_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prev = 2'h1;
  logic signed [7:0] vin;
  int cnt, el, acc, zcnt;
  assign vin = vin_in[{chan_sel_hi_in, chan_sel_lo_in}];
  assign el = (phase_code_in != prev) ? 0 : cnt;
  always_ff @(posedge clk_in) begin
    prev <= phase_code_in;
    cnt <= (phase_code_in != prev) ? 1 : cnt + 1;
    case (phase_code_in)
      2'h2: acc <= acc + ((vin < 0) ? -vin : vin);
      2'h3: acc <= (acc > 0) ? acc - 1 : 0;
      default: acc <= 0;
    endcase
    zcnt <= (phase_code_in == 2'h3 && acc == 0) ? zcnt + 1 : 0;
  end
  always_comb begin
    case (phase_code_in)
      2'h1: zero_cross_out = el >= null_low_in;
      // Noisy early in integration, settled later
      2'h2: zero_cross_out = (el < 3) ^ (vin >= 0);
      // Negative input: comparator output still lags low into the ramp
      2'h3: zero_cross_out = (vin < 0 && el < LAG) ? 1'b0 : zcnt < LAG;
      default: zero_cross_out = el >= 3;
    endcase
  end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; $display("Error %s exp %0h got %0h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsps_pkg::*;
  logic clk = 0, rst = 1, hwrite = 0, hsel = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, st;
  logic [1:0] htrans = 0, lastph = 2'h1;
  logic [2:0] hsize = 3'h2;
  logic [15:0] null_low = 0;
  logic signed [7:0] vin [4] = '{1, 2, 3, 4};
  wire logic [31:0] hrdata;
  wire logic hready, zc, hi, lo, hresp;
  wire logic [1:0] ph;
  int error_cnt = 0, tests_run = 0, cyc = 0, run = 0, res0;
  int plen [4];
  always #5 clk = ~clk;
  dsps_sequencer dut (.CLK_SYS_IN(clk), .RST_IN(rst), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HSEL_IN(hsel), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .ZERO_CROSS_OUT_IN(zc), .PHASE_CODE_OUT(ph),
    .CHAN_SEL_HI_OUT(hi), .CHAN_SEL_LO_OUT(lo));
  dsps_fe_model fe (.clk_in(clk), .phase_code_in(ph), .chan_sel_hi_in(hi), .chan_sel_lo_in(lo), .vin_in(vin),
    .null_low_in(null_low), .zero_cross_out(zc));
  // Length of the last completed run of each phase code
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ph != lastph) begin
      plen[lastph] <= run;
      run <= 1;
    end else run <= run + 1;
    lastph <= ph;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK("hresp", HRESP_OKAY[0], hresp)
  endtask
  task automatic conv(input logic [1:0] ch);
    bus(1, OFF_CTRL, {26'h0, ch, 4'h1});
    bus(0, OFF_STATUS, 0);
    do bus(0, OFF_STATUS, 0); while (rd[ST_BUSY_BIT] !== 1'b0 || rd[ST_DONE_BIT] !== 1'b1);
    st = rd;
    `CHK("chan pins", ch, {hi, lo})
    `CHK("integ len", 20, plen[2])
    `CHK("st chan", ch, st[ST_CHAN_LSB +: 2])
    `CHK("st phase", PH_NULL, st[ST_PHASE_LSB +: 2])
    bus(0, OFF_RESULT, 0);
  endtask
  task automatic t_regs;
    bus(0, OFF_INT_LEN, 0); `CHK("int len", INT_LEN_RST, rd)
    bus(0, OFF_NULL_LEN, 0); `CHK("null len", NULL_LEN_RST, rd)
    bus(0, OFF_MAX_RAMP, 0); `CHK("ramp max", MAX_RAMP_RST, rd)
    bus(1, 8'h18, 32'h5a5a5a5a);
    bus(0, 8'h18, 0); `CHK("unmapped", 32'h0, rd)
    bus(1, OFF_INT_LEN, 20);
    bus(1, OFF_NULL_LEN, 20);
    bus(1, OFF_MAX_RAMP, 200);
    repeat (50) @(posedge clk);
    `CHK("idle phase", PH_NULL, ph)
  endtask
  task automatic t_chan;
    for (int c = 0; c < 4; c++) begin
      conv(2'(c));
      if (c == 0) res0 = rd;
      else `CHK("mag step", 20 * c, rd - res0)
      `CHK("sign pos", 1'b1, st[ST_SIGN_BIT])
      `CHK("null min", 1, plen[1] >= 20)
      `CHK("no over", 1'b0, st[ST_OVR_BIT])
    end
  endtask
  task automatic t_neg;
    vin[1] <= -8'sd2;
    conv(2'h1);
    `CHK("sign neg", 1'b0, st[ST_SIGN_BIT])
    `CHK("mag neg", res0 + 20, rd)
  endtask
  task automatic t_late;
    null_low <= 150;
    conv(2'h0);
    `CHK("null exit", 1, plen[1] >= 150 && plen[1] <= 153)
    null_low <= 0;
  endtask
  task automatic t_over;
    vin[2] <= 8'sd20;
    conv(2'h2);
    `CHK("over range", 1'b1, st[ST_OVR_BIT])
    `CHK("over count", 200, rd)
    `CHK("ramp cut", 1, plen[3] >= 199 && plen[3] <= 201)
    `CHK("back null", PH_NULL, ph)
  endtask
  task automatic results;
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_chan();
    t_neg();
    t_late();
    t_over();
    results();
  end
endmodule
bind dsps_sequencer dsps_props chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
  .ZERO_CROSS_OUT_IN(ZERO_CROSS_OUT_IN), .PHASE_CODE_OUT(PHASE_CODE_OUT), .CHAN_SEL_HI_OUT(CHAN_SEL_HI_OUT),
  .CHAN_SEL_LO_OUT(CHAN_SEL_LO_OUT));
`default_nettype wire
